/* File: rtl/usd_pkg.sv */
// Constants, offsets and types shared by the status, scratch and
// low-power divisor block. Assumes a 32-bit Avalon-MM byte address.
package usd_pkg;

    // ************************************************************
    // Bus shape and widths
    // ************************************************************
    localparam int unsigned ADDR_W   = 32;
    localparam int unsigned DATA_W   = 32;
    localparam int unsigned BYTE_W   = 8;
    localparam int unsigned LP_DIV_W = 16;
    localparam int unsigned EV_W     = 2;
    localparam int unsigned GAP_W    = 21;

    // ************************************************************
    // Register byte addresses
    // ************************************************************
    localparam logic [31:0] MODEM_STATUS_ADDR    = 32'h5000_1118;
    localparam logic [31:0] GENERAL_SCRATCH_ADDR = 32'h5000_111C;
    localparam logic [31:0] LP_DIV_LOW_ADDR      = 32'h5000_1120;
    localparam logic [31:0] LP_DIV_HIGH_ADDR     = 32'h5000_1124;
    localparam logic [31:0] LINE_CONTROL_ADDR    = 32'h5000_1180;
    localparam logic [31:0] MODEM_CONTROL_ADDR   = 32'h5000_1184;
    localparam logic [31:0] IRQ_STATUS_ADDR      = 32'h5000_1188;
    localparam logic [31:0] IRQ_ENABLE_ADDR      = 32'h5000_118C;
    localparam logic [31:0] IRQ_CLEAR_ADDR       = 32'h5000_1190;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int unsigned DCTS_POS     = 0;
    localparam int unsigned CTS_POS      = 4;
    localparam int unsigned RTS_POS      = 1;
    localparam int unsigned LOOPBACK_POS = 4;
    localparam int unsigned DIVISOR_LATCH_ACCESS_BIT_POS     = 7;
    localparam int unsigned EV_DCTS_POS  = 0;
    localparam int unsigned EV_PULSE_POS = 1;

    // ************************************************************
    // Reset values and fixed counts
    // ************************************************************
    localparam logic [7:0]  SCRATCH_RST       = 8'h00;
    localparam logic [7:0]  LP_DIV_LOW_RST    = 8'h00;
    localparam logic [7:0]  LP_DIV_HIGH_RST   = 8'h00;
    localparam logic [7:0]  LINE_CONTROL_RST  = 8'h00;
    localparam logic [7:0]  MODEM_CONTROL_RST = 8'h00;
    localparam logic [1:0]  IRQ_RST           = 2'h0;
    localparam logic [1:0]  SYNC_HIGH_RST     = 2'h3;
    localparam logic [1:0]  SYNC_LOW_RST      = 2'h0;
    localparam logic [15:0] OVERSAMPLE        = 16'h0010;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [0:0] {
        USD_BUS_IDLE   = 1'h0,
        USD_BUS_ANSWER = 1'h1
    } usd_bus_state_t;

endpackage

/* File: rtl/usd_lp_if.sv */
// Carrier between the register block and the infrared pulse detector.
// Assumes both ends run on the one system clock.
`timescale 1ns/1ps
`default_nettype none

interface usd_lp_if;
    logic lp_enable;
    logic x16_tick;
    logic ir_level;
    logic pulse_found;

    // Register block drives the timing, detector reports pulses
    modport src (output lp_enable, output x16_tick, output ir_level,
                 input pulse_found);
    modport det (input lp_enable, input x16_tick, input ir_level,
                 output pulse_found);
endinterface

`default_nettype wire

/* File: rtl/usd_divider.sv */
// Programmable tick divider: one output pulse every divisor input ticks.
// Assumes divisor is quasi-static; zero stops the output entirely.
`timescale 1ns/1ps
`default_nettype none

module usd_divider #(
    parameter int unsigned W = 16
) (
    // Clock and reset
    input  wire logic         clock,
    input  wire logic         resetn,
    // Rate control
    input  wire logic         tick_in,
    input  wire logic [W-1:0] divisor,
    // Divided pulse
    output var  logic         tick_out
);
    logic [W-1:0] count;
    logic [W-1:0] next_count;
    logic         next_tick_out;

    // Wrap on >= so a shrinking divisor never overruns
    always_comb begin
        next_count    = count;
        next_tick_out = 1'h0;
        if (divisor == '0) begin
            next_count = '0;
        end else if (tick_in) begin
            if (count >= divisor - 1'b1) begin
                next_count    = '0;
                next_tick_out = 1'h1;
            end else begin
                next_count = count + 1'b1;
            end
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            count    <= '0;
            tick_out <= 1'h0;
        end else begin
            count    <= next_count;
            tick_out <= next_tick_out;
        end
    end
endmodule

`default_nettype wire

/* File: rtl/usd_ir_detect.sv */
// Infrared receive pulse detector timed by the low-power x16 tick.
// Assumes ir_level is already synchronised to clock.
`timescale 1ns/1ps
`default_nettype none

module usd_ir_detect (
    // Clock and reset
    input  wire logic clock,
    input  wire logic resetn,
    // Timing in, pulses out
    usd_lp_if.det     lp
);
    logic prev_level;
    logic saw_tick;
    logic next_prev_level;
    logic next_saw_tick;
    logic next_found;

    // A pulse counts only if a tick fell inside its high phase
    always_comb begin
        next_prev_level = lp.ir_level;
        next_saw_tick   = saw_tick;
        next_found      = 1'h0;
        if (!lp.lp_enable) begin
            next_saw_tick = 1'h0;
        end else begin
            if (lp.ir_level && lp.x16_tick) begin
                next_saw_tick = 1'h1;
            end
            if (prev_level && !lp.ir_level) begin
                next_found    = saw_tick;
                next_saw_tick = 1'h0;
            end
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            prev_level     <= 1'h0;
            saw_tick       <= 1'h0;
            lp.pulse_found <= 1'h0;
        end else begin
            prev_level     <= next_prev_level;
            saw_tick       <= next_saw_tick;
            lp.pulse_found <= next_found;
        end
    end

    a_pulse_needs_tick: assert property (@(posedge clock) disable iff
        (!resetn) lp.pulse_found |-> $past(lp.lp_enable))
        else $error("pulse reported without low-power clock");
endmodule

`default_nettype wire

/* File: rtl/usd_top.sv */
// Modem status delta flag, scratch and low-power divisor block.
// Assumes an Avalon-MM master on clock and async pins on cts_n, ir_in.
//
// The Avalon-MM register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module usd_top (
    // Clock and reset
    input  wire logic                         clock,
    input  wire logic                         resetn,
    // Avalon-MM slave
    input  wire logic [usd_pkg::ADDR_W-1:0]   address,
    input  wire logic                         read,
    input  wire logic                         write,
    input  wire logic [usd_pkg::DATA_W-1:0]   writedata,
    input  wire logic [3:0]                   byteenable,
    output var  logic [usd_pkg::DATA_W-1:0]   readdata,
    output var  logic                         waitrequest,
    // Modem handshake pins
    input  wire logic                         cts_n,
    output var  logic                         rts_n,
    // Infrared receive pin and low-power timing
    input  wire logic                         ir_in,
    output var  logic                         lp_baud_tick,
    output var  logic                         ir_pulse_found,
    // Interrupt
    output var  logic                         irq
);
    import usd_pkg::*;

    // ************************************************************
    // Declarations
    // ************************************************************
    usd_lp_if lp ();

    usd_bus_state_t      state;
    usd_bus_state_t      next_state;
    logic [DATA_W-1:0]   next_readdata;
    logic [DATA_W-1:0]   rd_value;
    logic [1:0]          cts_sync;
    logic [1:0]          ir_sync;
    logic [7:0]          scratch;
    logic [7:0]          lp_low;
    logic [7:0]          lp_high;
    logic [7:0]          line_control;
    logic [7:0]          modem_control;
    logic                dcts;
    logic                cts_prev;
    logic [EV_W-1:0]     irq_status;
    logic [EV_W-1:0]     irq_enable;
    logic [7:0]          next_scratch;
    logic [7:0]          next_lp_low;
    logic [7:0]          next_lp_high;
    logic [7:0]          next_line_control;
    logic [7:0]          next_modem_control;
    logic                next_dcts;
    logic [EV_W-1:0]     next_irq_status;
    logic [EV_W-1:0]     next_irq_enable;
    logic                next_rts_n;
    logic                next_irq;
    logic                sel_msr;
    logic                sel_scr;
    logic                sel_lpl;
    logic                sel_lph;
    logic                sel_lcr;
    logic                sel_mcr;
    logic                sel_ist;
    logic                sel_ien;
    logic                sel_icl;
    logic                wr_acc;
    logic                rd_acc;
    logic                divisor_latch_access_bit;
    logic                loopback;
    logic                cts_level;
    logic                cts_change;
    logic [LP_DIV_W-1:0] lp_div;
    logic [EV_W-1:0]     events;

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    // Only the second stage is read, the first may be metastable
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            cts_sync <= SYNC_HIGH_RST;
            ir_sync  <= SYNC_LOW_RST;
        end else begin
            cts_sync <= {cts_sync[0], cts_n};
            ir_sync  <= {ir_sync[0], ir_in};
        end
    end

    // ************************************************************
    // Address decode and read mux
    // ************************************************************
    assign divisor_latch_access_bit     = line_control[DIVISOR_LATCH_ACCESS_BIT_POS];
    assign loopback = modem_control[LOOPBACK_POS];
    assign lp_div   = {lp_high, lp_low};

    always_comb begin
        sel_msr  = 1'h0;
        sel_scr  = 1'h0;
        sel_lpl  = 1'h0;
        sel_lph  = 1'h0;
        sel_lcr  = 1'h0;
        sel_mcr  = 1'h0;
        sel_ist  = 1'h0;
        sel_ien  = 1'h0;
        sel_icl  = 1'h0;
        rd_value = 32'h0000_0000; // Unmapped and reserved bits read zero
        if (address == MODEM_STATUS_ADDR) begin
            sel_msr            = 1'h1;
            rd_value[CTS_POS]  = cts_level;
            rd_value[DCTS_POS] = dcts;
        end else if (address == GENERAL_SCRATCH_ADDR) begin
            sel_scr       = 1'h1;
            rd_value[7:0] = scratch;
        end else if (address == LP_DIV_LOW_ADDR) begin
            sel_lpl       = 1'h1;
            rd_value[7:0] = divisor_latch_access_bit ? lp_low : 8'h00;
        end else if (address == LP_DIV_HIGH_ADDR) begin
            sel_lph       = 1'h1;
            rd_value[7:0] = divisor_latch_access_bit ? lp_high : 8'h00;
        end else if (address == LINE_CONTROL_ADDR) begin
            sel_lcr       = 1'h1;
            rd_value[7:0] = line_control;
        end else if (address == MODEM_CONTROL_ADDR) begin
            sel_mcr       = 1'h1;
            rd_value[7:0] = modem_control;
        end else if (address == IRQ_STATUS_ADDR) begin
            sel_ist             = 1'h1;
            rd_value[EV_W-1:0]  = irq_status;
        end else if (address == IRQ_ENABLE_ADDR) begin
            sel_ien             = 1'h1;
            rd_value[EV_W-1:0]  = irq_enable;
        end else if (address == IRQ_CLEAR_ADDR) begin
            sel_icl = 1'h1;
        end
    end

    // ************************************************************
    // Avalon handshake: one wait state on every access
    // ************************************************************
    assign waitrequest = (read | write) & (state == USD_BUS_IDLE);
    assign wr_acc      = (state == USD_BUS_ANSWER) & write;
    assign rd_acc      = (state == USD_BUS_ANSWER) & read;

    // Read data is captured a cycle early so it stands from a flop
    always_comb begin
        next_state    = USD_BUS_IDLE;
        next_readdata = readdata;
        case (state)
            USD_BUS_IDLE: begin
                if (read | write) begin
                    next_state = USD_BUS_ANSWER;
                end
                if (read) begin
                    next_readdata = rd_value;
                end
            end
            USD_BUS_ANSWER: begin
                next_state = USD_BUS_IDLE;
            end
            default: begin
                next_state = USD_BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state    <= USD_BUS_IDLE;
            readdata <= 32'h0000_0000;
        end else begin
            state    <= next_state;
            readdata <= next_readdata;
        end
    end

    // ************************************************************
    // Register file, delta flag and interrupts
    // ************************************************************
    // Loopback takes the level from the control bit, not the pin
    assign cts_level  = loopback ? modem_control[RTS_POS]
                                 : ~cts_sync[1];
    assign cts_change = cts_level != cts_prev;

    always_comb begin
        next_scratch       = scratch;
        next_lp_low        = lp_low;
        next_lp_high       = lp_high;
        next_line_control  = line_control;
        next_modem_control = modem_control;
        next_irq_enable    = irq_enable;
        events             = '0;
        events[EV_DCTS_POS]  = cts_change;
        events[EV_PULSE_POS] = lp.pulse_found;
        next_irq_status    = irq_status;
        if (wr_acc && byteenable[0]) begin
            // Only byte lane 0 exists; upper lanes are dropped
            if (sel_scr) begin
                next_scratch = writedata[7:0];
            end else if (sel_lpl && divisor_latch_access_bit) begin
                next_lp_low = writedata[7:0];
            end else if (sel_lph && divisor_latch_access_bit) begin
                next_lp_high = writedata[7:0];
            end else if (sel_lcr) begin
                next_line_control = writedata[7:0];
            end else if (sel_mcr) begin
                next_modem_control = writedata[7:0];
            end else if (sel_ien) begin
                next_irq_enable = writedata[EV_W-1:0];
            end else if (sel_icl) begin
                next_irq_status = irq_status & ~writedata[EV_W-1:0];
            end
        end
        // New events win over a clear in the same cycle
        next_irq_status = next_irq_status | events;
        // Clear only what the read returned, so no change is lost
        next_dcts = cts_change |
                    (dcts & ~(rd_acc & sel_msr &
                              readdata[DCTS_POS]));
        next_rts_n = next_modem_control[LOOPBACK_POS] |
                     ~next_modem_control[RTS_POS];
        next_irq   = |(next_irq_status & next_irq_enable);
    end

    // Clear-to-send history resets deasserted so a held pin sets the flag
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            scratch       <= SCRATCH_RST;
            lp_low        <= LP_DIV_LOW_RST;
            lp_high       <= LP_DIV_HIGH_RST;
            line_control  <= LINE_CONTROL_RST;
            modem_control <= MODEM_CONTROL_RST;
            irq_status    <= IRQ_RST;
            irq_enable    <= IRQ_RST;
            dcts          <= 1'h0;
            cts_prev      <= 1'h0;
            rts_n         <= 1'h1;
            irq           <= 1'h0;
        end else begin
            scratch       <= next_scratch;
            lp_low        <= next_lp_low;
            lp_high       <= next_lp_high;
            line_control  <= next_line_control;
            modem_control <= next_modem_control;
            irq_status    <= next_irq_status;
            irq_enable    <= next_irq_enable;
            dcts          <= next_dcts;
            cts_prev      <= cts_level;
            rts_n         <= next_rts_n;
            irq           <= next_irq;
        end
    end

    // ************************************************************
    // Low-power baud clock and infrared detector
    // ************************************************************
    assign lp.lp_enable = lp_div != '0;
    assign lp.ir_level  = ir_sync[1];
    assign ir_pulse_found = lp.pulse_found;

    // First stage gives the x16 tick, second the baud tick
    usd_divider #(.W(LP_DIV_W)) u_div_x16 (
        .clock    (clock),
        .resetn   (resetn),
        .tick_in  (1'h1),
        .divisor  (lp_div),
        .tick_out (lp.x16_tick)
    );

    usd_divider #(.W(LP_DIV_W)) u_div_baud (
        .clock    (clock),
        .resetn   (resetn),
        .tick_in  (lp.x16_tick & lp.lp_enable), // Late x16 tick ignored
        .divisor  (OVERSAMPLE),
        .tick_out (lp_baud_tick)
    );

    usd_ir_detect u_ir_detect (
        .clock  (clock),
        .resetn (resetn),
        .lp     (lp)
    );

    // ************************************************************
    // Checks
    // ************************************************************
    logic [GAP_W-1:0] gap_cnt;
    logic             gap_ok;
    logic [2:0]       since_reset;
    logic             dcts_seen;

    // Helper: baud period measured only with a settled divisor
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            gap_cnt     <= '0;
            gap_ok      <= 1'h0;
            since_reset <= 3'h0;
            dcts_seen   <= 1'h0;
        end else begin
            gap_cnt     <= lp_baud_tick ? GAP_W'(1) : gap_cnt + 1'b1;
            gap_ok      <= (wr_acc && (sel_lpl || sel_lph)) ? 1'h0
                         : (lp_baud_tick ? 1'h1 : gap_ok);
            since_reset <= (since_reset == 3'h7) ? 3'h7
                                                 : since_reset + 3'h1;
            dcts_seen   <= dcts_seen | dcts;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    sequence s_msr_read;
        rd_acc && sel_msr && readdata[DCTS_POS];
    endsequence

    a_dcts_sets_change: assert property (cts_change |=> dcts)
        else $error("delta flag missed a clear-to-send change");
    a_msr_read_clears: assert property (
        s_msr_read ##0 !cts_change |=> !dcts)
        else $error("modem status read did not clear delta flag");
    a_loop_tracks_rts: assert property (
        loopback && $stable(loopback) && $changed(modem_control[RTS_POS])
        |=> dcts)
        else $error("loopback request-to-send change not flagged");
    a_reset_held_cts: assert property (
        since_reset == 3'h3 && !loopback && cts_level
        |-> dcts || dcts_seen)
        else $error("held clear-to-send not flagged after reset");
    a_scratch_holds: assert property (
        wr_acc && byteenable[0] && sel_scr
        |=> scratch == $past(writedata[7:0]))
        else $error("scratch did not take written byte");
    a_lp_low_write: assert property (
        wr_acc && byteenable[0] && sel_lpl && divisor_latch_access_bit
        |=> lp_div[7:0] == $past(writedata[7:0]))
        else $error("low divisor byte not written");
    a_lp_high_write: assert property (
        wr_acc && byteenable[0] && sel_lph && divisor_latch_access_bit
        |=> lp_div[15:8] == $past(writedata[7:0]))
        else $error("high divisor byte not written");
    a_divisor_latch_access_bit_gate: assert property (
        wr_acc && (sel_lpl || sel_lph) && !divisor_latch_access_bit
        |=> $stable(lp_div))
        else $error("divisor changed with latch access clear");
    a_baud_period: assert property (
        lp_baud_tick && gap_ok
        |-> gap_cnt == {1'h0, lp_div, 4'h0})
        else $error("low-power baud period wrong");
    a_zero_div_quiet: assert property (
        (lp_div == '0) [*2] |-> !lp.x16_tick && !lp_baud_tick
        ##1 !ir_pulse_found)
        else $error("activity with zero divisor");
    a_upper_zero: assert property (
        state == USD_BUS_ANSWER && read && (sel_scr || sel_lpl || sel_lph)
        |-> readdata[31:8] == 24'h00_0000)
        else $error("reserved bits read nonzero");
endmodule

`default_nettype wire

/* File: testbench/usd_modem_model.sv */
// Data set model: drives clear-to-send and infrared receive pins.
// Assumes the bench sets the wanted levels just after an edge.
`timescale 1ns/1ps
`default_nettype none
module usd_modem_model (
    // Wanted levels
    input  wire logic cts_want,
    input  wire logic ir_want,
    // Pins
    output wire logic cts_n,
    output wire logic ir_in
);
    // Clear-to-send is active low on the wire
    assign cts_n = ~cts_want;
    assign ir_in = ir_want;
endmodule
`default_nettype wire

/* File: testbench/tb_usd_top.sv */
// Bench for the modem status, scratch and low-power divisor block.
// Assumes usd_pkg, the design and the data set model are compiled.
`timescale 1ns/1ps
`default_nettype none
module tb_usd_top;
    import usd_pkg::*;
    // ****************
    // Signals
    // ****************
    logic        clock, resetn, read, write, cts_want, ir_want;
    logic        waitrequest, cts_n, rts_n, ir_in, tick, found, irq;
    logic [31:0] address, writedata, readdata, q;
    int          n_fail, checked, g;
    bit          f;
    usd_modem_model mdm_u (.cts_want(cts_want), .ir_want(ir_want),
        .cts_n(cts_n), .ir_in(ir_in));
    usd_top dut_u (.clock(clock), .resetn(resetn), .address(address),
        .read(read), .write(write), .writedata(writedata),
        .byteenable(4'hF), .readdata(readdata),
        .waitrequest(waitrequest), .cts_n(cts_n), .rts_n(rts_n),
        .ir_in(ir_in), .lp_baud_tick(tick), .ir_pulse_found(found),
        .irq(irq));
    // ****************
    // Tasks
    // ****************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic stop_test;
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // One bus cycle, held until waitrequest is seen low at an edge
    task automatic bus(input logic wr, input logic [31:0] a, d);
        int n;
        address   <= a;
        writedata <= d;
        write     <= wr;
        read      <= ~wr;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        if (waitrequest !== 1'b0) begin
            n_fail++;
            stop_test();
        end
        q = readdata;
        read  <= 1'b0;
        write <= 1'b0;
        // Extra edge so the next request never lands in this step
        @(posedge clock);
    endtask
    task automatic rd(input logic [31:0] a, e);
        bus(1'b0, a, 32'h0);
        chk(q, e);
    endtask
    // Edges between two baud ticks, -1 when none show up
    task automatic gap(output int r);
        int n;
        r = -1;
        for (n = 0; n < 5000 && tick !== 1'b1; n++) @(posedge clock);
        if (n < 5000) begin
            r = 0;
            do begin
                @(posedge clock);
                r++;
            end while (tick !== 1'b1 && r < 5000);
        end
    endtask
    // Wide infrared pulse; looks for the detector's report after it
    task automatic pulse(output bit hit);
        ir_want <= 1'b1;
        repeat (80) @(posedge clock);
        ir_want <= 1'b0;
        hit = 0;
        repeat (10) begin
            @(posedge clock);
            if (found === 1'b1) hit = 1;
        end
    endtask
    // ****************
    // Clock and tests
    // ****************
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    initial begin
        {resetn, read, write, ir_want, address, writedata} = '0;
        {n_fail, checked} = '0;
        cts_want = 1'b1;
        repeat (8) @(posedge clock);
        resetn <= 1'b1;
        repeat (4) @(posedge clock);
        rd(MODEM_STATUS_ADDR, 32'h11);
        rd(MODEM_STATUS_ADDR, 32'h10);
        cts_want <= 1'b0;
        repeat (5) @(posedge clock);
        rd(MODEM_STATUS_ADDR, 32'h01);
        bus(1'b1, MODEM_CONTROL_ADDR, 32'h12);
        cts_want <= 1'b1;
        repeat (5) @(posedge clock);
        rd(MODEM_STATUS_ADDR, 32'h11);
        rd(MODEM_STATUS_ADDR, 32'h10);
        $display("modem test ended");
        bus(1'b1, GENERAL_SCRATCH_ADDR, 32'hFFFF_FFA5);
        rd(GENERAL_SCRATCH_ADDR, 32'hA5);
        rd(32'h5000_1128, 32'h0);
        bus(1'b1, LP_DIV_LOW_ADDR, 32'h2);
        bus(1'b1, LINE_CONTROL_ADDR, 32'h80);
        rd(LP_DIV_LOW_ADDR, 32'h0);
        bus(1'b1, LP_DIV_LOW_ADDR, 32'hFF44);
        repeat (8) @(posedge clock);
        rd(LP_DIV_LOW_ADDR, 32'h44);
        gap(g);
        chk(g, 1088);
        bus(1'b1, IRQ_CLEAR_ADDR, 32'h3);
        bus(1'b1, IRQ_ENABLE_ADDR, 32'h2);
        pulse(f);
        chk(f, 1);
        rd(IRQ_STATUS_ADDR, 32'h2);
        chk(irq, 1);
        bus(1'b1, IRQ_CLEAR_ADDR, 32'h2);
        repeat (2) @(posedge clock);
        chk(irq, 0);
        $display("divisor test ended");
        bus(1'b1, LP_DIV_LOW_ADDR, 32'h0);
        bus(1'b1, LP_DIV_HIGH_ADDR, 32'h1);
        rd(LP_DIV_HIGH_ADDR, 32'h1);
        gap(g);
        chk(g, 4096);
        bus(1'b1, LP_DIV_HIGH_ADDR, 32'h0);
        gap(g);
        chk(g, -1);
        pulse(f);
        chk(f, 0);
        $display("zero divisor test ended");
        stop_test();
    end
endmodule
`default_nettype wire
